/* File: i2m_defs.vh */
// Register map, field positions, reset values and timing counts of the two-wire master
`ifndef I2M_DEFS_VH
`define I2M_DEFS_VH

// Register byte addresses on the core register port
`define I2M_ADDR_TX 8'h9a
`define I2M_ADDR_RX 8'h9b
`define I2M_ADDR_CFG 8'haf
`define I2M_ADDR_MODE 8'he8
`define I2M_ADDR_TARGET 8'he9
`define I2M_ADDR_STATUS 8'hea

// Reset value shared by every register
`define I2M_RESET_BYTE 8'h00

// Mode register fields
`define I2M_MODE_ENABLE 7
`define I2M_MODE_RATE_HI 6
`define I2M_MODE_RATE_LO 5
`define I2M_MODE_COUNT_HI 4
`define I2M_MODE_COUNT_LO 0

// Configuration register: port owner select, 1 gives the pins to this master
`define I2M_CFG_OWNER 0

// Target register fields
`define I2M_TARGET_DIR 0

// Status register fields
`define I2M_STAT_BUSY 7
`define I2M_STAT_NOACK 6
`define I2M_STAT_RXPEND 5
`define I2M_STAT_TXEMPTY 4
`define I2M_STAT_LEVEL_HI 3
`define I2M_STAT_LEVEL_LO 2
`define I2M_STAT_CLASH 1
`define I2M_STAT_TXOVF 0

// FIFO level codes
`define I2M_LEVEL_EMPTY 2'b00
`define I2M_LEVEL_HALF 2'b10
`define I2M_LEVEL_FULL 2'b11

// One bus bit is 16 core clocks times 2^rate; it is split into four quarters
`define I2M_BIT_CLOCKS 16
`define I2M_QUARTER_BASE 6'h04

// Default FIFO geometry
`define I2M_FIFO_DEPTH 4
`define I2M_FIFO_AW 2

`endif

/* File: i2m_fifo.v */
// Small byte FIFO in flip-flops, used for the transmit and the receive side
`include "i2m_defs.vh"

module i2m_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = `I2M_FIFO_DEPTH,
  parameter AW = `I2M_FIFO_AW
) (
  input wire clock,
  input wire clock_enable,
  input wire rst_n,
  input wire flush,
  input wire push,
  input wire [WIDTH-1:0] push_data,
  input wire pop,
  output wire [WIDTH-1:0] pop_data,
  output reg [AW:0] count,
  output wire full,
  output wire empty
);

  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  wire do_push;
  wire do_pop;

  // Full and empty straight from the count, so they never lie
  assign full = (count == DEPTH[AW:0]);
  assign empty = (count == {(AW+1){1'b0}});
  assign do_push = push & ~full & ~flush;
  assign do_pop = pop & ~empty & ~flush;
  assign pop_data = store[rd_ptr];

  // One storage register per entry
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1)
    begin : g_entry
      always @(posedge clock)
      begin
        if (!rst_n)
          store[i] <= {WIDTH{1'b0}};
        else if (clock_enable && do_push && {{(32-AW){1'b0}}, wr_ptr} == i)
          store[i] <= push_data;
      end
    end
  endgenerate

  // Pointers and count; flush wins over push and pop
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else if (clock_enable)
    begin
      if (flush)
      begin
        wr_ptr <= {AW{1'b0}};
        rd_ptr <= {AW{1'b0}};
        count <= {(AW+1){1'b0}};
      end
      else
      begin
        if (do_push)
          wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
        if (do_pop)
          rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
        if (do_push && !do_pop)
          count <= count + {{AW{1'b0}}, 1'b1};
        else if (do_pop && !do_push)
          count <= count - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule // i2m_fifo

/* File: i2m_master.v */
// Two-wire bus master with transmit and receive FIFOs behind a core register port
//
// Contract
// - Shared pins belong to this master only while the owner select bit picks it.
// - Both lines are driven open-drain: pull low or release, never drive high.
// - Start, address with direction, slave acknowledge, data, then stop to idle.
// - Bus clock is core clock over 16 times two to the rate field.
// - Target register holds address in bits 7..1, direction in bit 0; writing it starts.
// - Direction 1 reads into receive FIFO; direction 0 sends bytes from transmit FIFO.
// - Mode bit 7 enables the interface; then a target write starts communication.
// - A read stops after receive count plus one bytes, or earlier on error.
// - Busy bit 7 is set while in use; the transmit FIFO is drained meanwhile.
// - Missing acknowledge sets status bit 6, halts the transfer; cleared by writing 0.
// - Status bit 5 is set while the receive FIFO holds a byte; write 0 clears.
// - Status bit 4 is set while the transmit FIFO is empty; write 0 clears.
// - Level field shows active FIFO: 00 empty, 10 half full, 11 full.
// - Status bit 1 flags a write and read in the same cycle; write 0 clears.
// - Status bit 0 flags a transmit write while the FIFO is full; write 0 clears.
// - Registers sit at the locations shared with the serial port's registers.
// - Receive and transmit FIFOs are four bytes deep each.
// - Reads acknowledge each byte automatically and not-acknowledge the final byte.
// - Rewriting the target mid-transfer gives a repeated start instead of a stop.
// - Empty transmit FIFO when a byte is needed stops; write errors flush it.
`include "i2m_defs.vh"

module i2m_master #(
  parameter FIFO_DEPTH = `I2M_FIFO_DEPTH,
  parameter FIFO_AW = `I2M_FIFO_AW
) (
  input wire clock,
  input wire clock_enable,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  input wire scl_in,
  output reg scl_out,
  output reg scl_oe,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe
);

  localparam ST_IDLE = 2'd0;
  localparam ST_START = 2'd1;
  localparam ST_BIT = 2'd2;
  localparam ST_STOP = 2'd3;

  localparam KIND_ADDR = 2'd0;
  localparam KIND_WDATA = 2'd1;
  localparam KIND_RDATA = 2'd2;

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and state
  reg [7:0] mode_reg, target_reg, cfg_reg, shift;
  reg noack_flag, rx_pend_flag, tx_empty_flag, clash_flag, tx_ovf_flag;
  reg scl_meta, scl_sync, sda_meta, sda_sync;
  reg [1:0] state, phase, kind;
  reg [3:0] bit_cnt;
  reg [4:0] rx_done;
  reg cur_read, ack_bit, restart_pending;
  reg [5:0] div_cnt;

  wire active, tick, busy, last_rx, byte_end, noack_set, want_wbyte, target_wr;
  wire tx_full, tx_empty, rx_empty, tx_push, tx_pop, tx_flush, rx_push, rx_pop;
  wire [1:0] rate, level;
  wire [4:0] rx_limit;
  wire [5:0] quarter_len;
  wire [7:0] tx_data, rx_data;
  wire [FIFO_AW:0] tx_count, rx_count, act_count;

  ////////////////////////////////////////////////////////////////////////////////
  // Decoded controls
  assign active = mode_reg[`I2M_MODE_ENABLE] & cfg_reg[`I2M_CFG_OWNER];
  assign rate = mode_reg[`I2M_MODE_RATE_HI:`I2M_MODE_RATE_LO];
  assign rx_limit = mode_reg[`I2M_MODE_COUNT_HI:`I2M_MODE_COUNT_LO];
  assign busy = (state != ST_IDLE);
  assign target_wr = reg_write & (reg_addr == `I2M_ADDR_TARGET);

  // Quarter bit is 4 << rate clocks, so a whole bit is 16 << rate
  assign quarter_len = `I2M_QUARTER_BASE << rate;
  assign tick = busy & (div_cnt == quarter_len - 6'h01);

  // Byte counted from zero, so limit+1 bytes end on index limit
  assign last_rx = (rx_done == rx_limit);
  assign byte_end = tick & (state == ST_BIT) & (phase == 2'd3) & (bit_cnt == 4'd8);
  assign noack_set = byte_end & (kind != KIND_RDATA) & ack_bit;

  // Next byte of a write is pulled only when acknowledged and not restarting
  assign want_wbyte = byte_end & ~ack_bit & ~restart_pending &
                      ((kind == KIND_WDATA) | ((kind == KIND_ADDR) & ~cur_read));

  ////////////////////////////////////////////////////////////////////////////////
  // FIFO hookup
  assign tx_push = reg_write & (reg_addr == `I2M_ADDR_TX) & ~reg_read;
  assign tx_pop = want_wbyte & ~tx_empty;
  assign tx_flush = ~active | (noack_set & ~cur_read);
  assign rx_push = byte_end & (kind == KIND_RDATA);
  assign rx_pop = reg_read & (reg_addr == `I2M_ADDR_RX) & ~reg_write;

  i2m_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_tx_fifo (
    .clock(clock), .clock_enable(clock_enable), .rst_n(rst_n), .flush(tx_flush), .push(tx_push),
    .push_data(reg_wdata), .pop(tx_pop), .pop_data(tx_data), .count(tx_count), .full(tx_full),
    .empty(tx_empty));

  // A full receive FIFO just drops further bytes, so its full flag is not needed
  i2m_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_rx_fifo (
    .clock(clock), .clock_enable(clock_enable), .rst_n(rst_n), .flush(1'b0), .push(rx_push),
    .push_data(shift), .pop(rx_pop), .pop_data(rx_data), .count(rx_count), .full(),
    .empty(rx_empty));

  // Level of the FIFO that the current direction uses; 01 never shown
  assign act_count = target_reg[`I2M_TARGET_DIR] ? rx_count : tx_count;
  assign level = (act_count == {(FIFO_AW+1){1'b0}}) ? `I2M_LEVEL_EMPTY :
                 (act_count == FIFO_DEPTH[FIFO_AW:0]) ? `I2M_LEVEL_FULL : `I2M_LEVEL_HALF;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
    end
    else if (clock_enable)
    begin
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Software registers and sticky flags; a hardware set beats a software clear
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      mode_reg <= `I2M_RESET_BYTE;
      target_reg <= `I2M_RESET_BYTE;
      cfg_reg <= `I2M_RESET_BYTE;
      noack_flag <= 1'b0;
      rx_pend_flag <= 1'b0;
      tx_empty_flag <= 1'b0;
      clash_flag <= 1'b0;
      tx_ovf_flag <= 1'b0;
    end
    else if (clock_enable)
    begin
      if (reg_write && reg_addr == `I2M_ADDR_MODE)
        mode_reg <= reg_wdata;
      if (reg_write && reg_addr == `I2M_ADDR_CFG)
        cfg_reg <= reg_wdata & 8'h01; // Only the owner bit is kept
      if (target_wr)
        target_reg <= reg_wdata;
      // Clears by writing 0 first, then the sets override them
      if (reg_write && reg_addr == `I2M_ADDR_STATUS)
      begin
        if (!reg_wdata[`I2M_STAT_NOACK])
          noack_flag <= 1'b0;
        if (!reg_wdata[`I2M_STAT_RXPEND])
          rx_pend_flag <= 1'b0;
        if (!reg_wdata[`I2M_STAT_TXEMPTY])
          tx_empty_flag <= 1'b0;
        if (!reg_wdata[`I2M_STAT_CLASH])
          clash_flag <= 1'b0;
        if (!reg_wdata[`I2M_STAT_TXOVF])
          tx_ovf_flag <= 1'b0;
      end
      if (noack_set)
        noack_flag <= 1'b1;
      if (!rx_empty)
        rx_pend_flag <= 1'b1;
      if (tx_empty)
        tx_empty_flag <= 1'b1;
      if (reg_write && reg_read)
        clash_flag <= 1'b1;
      if (tx_push && tx_full)
        tx_ovf_flag <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data, valid only in the cycle after the read strobe
  always @(posedge clock)
  begin
    if (!rst_n)
      reg_rdata <= `I2M_RESET_BYTE;
    else if (clock_enable)
    begin
      if (!reg_read)
        reg_rdata <= 8'h00;
      else
        case (reg_addr)
          `I2M_ADDR_RX: reg_rdata <= rx_data;
          `I2M_ADDR_CFG: reg_rdata <= cfg_reg;
          `I2M_ADDR_MODE: reg_rdata <= mode_reg;
          `I2M_ADDR_TARGET: reg_rdata <= target_reg;
          `I2M_ADDR_STATUS: reg_rdata <= {busy, noack_flag, rx_pend_flag, tx_empty_flag,
                                          level, clash_flag, tx_ovf_flag};
          default: reg_rdata <= 8'h00; // Write-only buffer and unmapped read as zero
        endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Quarter-bit divider, held at zero when idle so every frame starts aligned
  always @(posedge clock)
  begin
    if (!rst_n)
      div_cnt <= 6'h00;
    else if (clock_enable)
    begin
      if (!busy || tick)
        div_cnt <= 6'h00;
      else
        div_cnt <= div_cnt + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus sequencer; each tick ends one quarter of a bit
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      phase <= 2'd0;
      bit_cnt <= 4'd0;
      shift <= 8'h00;
      kind <= KIND_ADDR;
      rx_done <= 5'd0;
      cur_read <= 1'b0;
      ack_bit <= 1'b0;
      restart_pending <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
    else if (clock_enable)
    begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      if (!active)
      begin
        // Abandon at once and let go of both lines
        state <= ST_IDLE;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
        restart_pending <= 1'b0;
      end
      else
      begin
        if (target_wr && busy)
          restart_pending <= 1'b1;
        case (state)
          ST_IDLE:
          begin
            phase <= 2'd0;
            if (target_wr)
              state <= ST_START;
          end
          ST_START:
            if (tick)
            begin
              phase <= phase + 2'd1;
              case (phase)
                2'd0: sda_oe <= 1'b0;
                2'd1: scl_oe <= 1'b0;
                2'd2: sda_oe <= 1'b1;
                default:
                begin
                  scl_oe <= 1'b1;
                  shift <= target_reg;
                  cur_read <= target_reg[`I2M_TARGET_DIR];
                  kind <= KIND_ADDR;
                  bit_cnt <= 4'd0;
                  rx_done <= 5'd0;
                  restart_pending <= target_wr;
                  state <= ST_BIT;
                end
              endcase
            end
          ST_BIT:
            if (tick && !(phase == 2'd2 && !scl_sync))
            begin
              // Phase 2 waits for a stretched clock to rise
              phase <= phase + 2'd1;
              case (phase)
                2'd0:
                  if (bit_cnt != 4'd8)
                    sda_oe <= (kind != KIND_RDATA) & ~shift[7];
                  else
                    sda_oe <= (kind == KIND_RDATA) & ~last_rx;
                2'd1: scl_oe <= 1'b0;
                2'd2:
                  if (bit_cnt != 4'd8)
                  begin
                    shift <= {shift[6:0], sda_sync};
                    // Sent a 1 but the line is low: another master won
                    if (kind != KIND_RDATA && !sda_oe && !sda_sync)
                    begin
                      state <= ST_IDLE;
                      sda_oe <= 1'b0;
                      scl_oe <= 1'b0;
                    end
                  end
                  else
                    ack_bit <= sda_sync;
                default:
                begin
                  scl_oe <= 1'b1;
                  if (bit_cnt != 4'd8)
                    bit_cnt <= bit_cnt + 4'd1;
                  else
                  begin
                    bit_cnt <= 4'd0;
                    if (kind != KIND_RDATA && ack_bit)
                      state <= ST_STOP;
                    else if (restart_pending)
                      state <= ST_START;
                    else if (kind == KIND_RDATA)
                    begin
                      rx_done <= rx_done + 5'd1;
                      if (last_rx)
                        state <= ST_STOP;
                    end
                    else if (cur_read)
                      kind <= KIND_RDATA;
                    else if (!tx_empty)
                    begin
                      shift <= tx_data;
                      kind <= KIND_WDATA;
                    end
                    else
                      state <= ST_STOP;
                  end
                end
              endcase
            end
          ST_STOP:
            if (tick)
            begin
              phase <= phase + 2'd1;
              case (phase)
                2'd0: sda_oe <= 1'b1;
                2'd1: scl_oe <= 1'b0;
                2'd2: sda_oe <= 1'b0;
                default: state <= restart_pending ? ST_START : ST_IDLE;
              endcase
            end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

endmodule // i2m_master

/* File: i2m_master_checker.sv */
// Port-level assertions for the two-wire master, bound to its top module
module i2m_master_checker #(
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW = 2
) (
  input wire clock,
  input wire clock_enable,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  input wire [7:0] reg_rdata,
  input wire scl_in,
  input wire scl_out,
  input wire scl_oe,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  reg en_bit;
  reg own_bit;
  reg [1:0] rate;
  reg [15:0] rel_cnt;
  wire [15:0] half_bit;

  // Half a bus bit is eight core clocks scaled by the rate code
  assign half_bit = 16'h0008 << rate;

  ////////////////////////////////////////////////////////////////////////////
  // Shadow of enable, owner and rate; run length of a released clock line
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      en_bit <= 1'b0;
      own_bit <= 1'b0;
      rate <= 2'b00;
      rel_cnt <= 16'h0000;
    end
    else if (clock_enable)
    begin
      if (reg_write && reg_addr == 8'he8)
      begin
        en_bit <= reg_wdata[7];
        rate <= reg_wdata[6:5];
      end
      if (reg_write && reg_addr == 8'haf)
        own_bit <= reg_wdata[0];
      rel_cnt <= scl_oe ? 16'h0000 : rel_cnt + 16'h0001; // Wraps only when idle
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_open_drain: assert property (@(posedge clock) disable iff (!rst_n)
    !scl_out && !sda_out) else $error("bus line driven high");
  a_rdata_idle: assert property (@(posedge clock) disable iff (!rst_n)
    ($past(clock_enable) && !$past(reg_read)) |-> reg_rdata == 8'h00) else $error("read data outside read slot");
  a_off_released: assert property (@(posedge clock) disable iff (!rst_n)
    (!en_bit || !own_bit) [*3] |-> !scl_oe && !sda_oe) else $error("lines pulled while not owned");
  a_busy_in_use: assert property (@(posedge clock) disable iff (!rst_n)
    ($past(reg_read) && $past(reg_addr) == 8'hea && $past(scl_oe || sda_oe)) |-> reg_rdata[7])
    else $error("busy clear while bus in use");
  a_start_follows: assert property (@(posedge clock) disable iff (!rst_n)
    (clock_enable && reg_write && reg_addr == 8'he9 && en_bit && own_bit && !scl_oe && !sda_oe)
    |-> ##[1:1000] sda_oe) else $error("target write gave no start");
  a_half_bit: assert property (@(posedge clock) disable iff (!rst_n)
    ($rose(scl_oe) && !sda_oe) |-> rel_cnt == half_bit) else $error("clock high time wrong");
  a_stop_idle: assert property (@(posedge clock) disable iff (!rst_n)
    ($fell(sda_oe) && !scl_oe && !$past(scl_oe)) |-> (!scl_oe && !sda_oe) [*3])
    else $error("bus not idle after stop");
  a_clash_seen: assert property (@(posedge clock) disable iff (!rst_n)
    (clock_enable && reg_write && reg_read) ##[1:2] (reg_read && !reg_write && reg_addr == 8'hea)
    |=> reg_rdata[1]) else $error("clash flag missing");
endmodule // i2m_master_checker

bind i2m_master i2m_master_checker #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW)) i2m_master_checker_inst (
  .clock(clock), .clock_enable(clock_enable), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .scl_in(scl_in), .scl_out(scl_out),
  .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));

/* File: i2m_slave_model.sv */
// Behavioural two-wire slave: acknowledges its address, stores writes, sends a counting pattern
module i2m_slave_model #(
  parameter logic [6:0] ADDR = 7'h2b,
  parameter logic [7:0] START = 8'h3c
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic refuse,
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] shift, tx_byte, pat;
  logic active, addr_ph, sending;
  int bitn, starts, stops;
  logic [7:0] got[$];

  initial
  begin
    sda_pull = 1'b0;
    active = 1'b0;
    pat = START;
    starts = 0;
    stops = 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start and stop are data edges while the clock line is high
  always @(negedge sda)
    if (scl)
    begin
      active = 1'b1;
      addr_ph = 1'b1;
      sending = 1'b0;
      bitn = -1;
      starts++;
    end
  always @(posedge sda)
    if (scl)
    begin
      active = 1'b0;
      sda_pull = 1'b0;
      stops++;
    end

  // Sample on the rising clock; a master not-acknowledge ends our sending
  always @(posedge scl)
    if (active)
    begin
      if (bitn >= 0 && bitn < 8)
        shift = {shift[6:0], sda};
      else if (bitn == 8 && sending && !addr_ph && sda)
        active = 1'b0;
    end

  // Drive only while the clock is low, so no false start or stop is made
  always @(negedge scl)
    if (active)
    begin
      if (bitn < 0)
        bitn = 0;
      else if (bitn == 7)
      begin
        bitn = 8;
        if (addr_ph)
        begin
          sending = shift[0];
          if (shift[7:1] == ADDR && !refuse)
            sda_pull = 1'b1;
          else
            active = 1'b0;
        end
        else if (sending)
          sda_pull = 1'b0;
        else
        begin
          got.push_back(shift);
          sda_pull = !refuse;
        end
      end
      else if (bitn == 8)
      begin
        bitn = 0;
        addr_ph = 1'b0;
        sda_pull = 1'b0;
        if (sending)
        begin
          tx_byte = pat;
          pat = pat + 8'h01;
          sda_pull = !tx_byte[7];
        end
      end
      else
      begin
        if (sending && !addr_ph)
          sda_pull = !tx_byte[6 - bitn];
        bitn++;
      end
    end
endmodule // i2m_slave_model

/* File: i2m_master_test.sv */
// Self-checking bench for the two-wire master against a slave model
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module i2m_master_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] SLV = 7'h2b;
  localparam logic [7:0] P0 = 8'h3c;
  logic clock, rst_n, clock_enable, reg_write, reg_read, refuse;
  logic [7:0] reg_addr, reg_wdata, d, e8, g8;
  wire [7:0] reg_rdata;
  wire scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe, sda_pull;
  int failures, compares, txn, rxn, seed, r, s0, t0;
  logic dir, noack, rxp, txe, clash, ovf;
  logic [7:0] txq[$];
  logic [7:0] regs[7] = '{8'h9a, 8'h9b, 8'haf, 8'he8, 8'he9, 8'hea, 8'h10};

  // Pull-ups on both lines; the wire is low if anyone pulls
  assign scl_in = !scl_oe;
  assign sda_in = !sda_oe && !sda_pull;

  i2m_master i2m_master_inst (.clock(clock), .clock_enable(clock_enable), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .scl_in(scl_in),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));
  i2m_slave_model #(.ADDR(SLV), .START(P0)) i2m_slave_model_inst (.scl(scl_in), .sda(sda_in), .refuse(refuse),
    .sda_pull(sda_pull));

  ////////////////////////////////////////////////////////////////////////////
  // 250 MHz core clock and a watchdog against hangs
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial
  begin
    repeat (100000) @(posedge clock);
    failures++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status model: sticky flags, level of the FIFO picked by direction
  function automatic logic [7:0] exp_stat;
    int n;
    n = dir ? rxn : txn;
    return {1'b0, noack, rxp, txe, (n == 0) ? 2'b00 : (n == 4) ? 2'b11 : 2'b10, clash, ovf};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic chk_stat;
    rxp |= (rxn != 0);
    txe |= (txn == 0);
    rd(8'hea);
    `CHK("status", exp_stat(), d)
  endtask
  // Writing zeros clears every flag whose cause has gone
  task automatic clr;
    wr(8'hea, 8'h00);
    {noack, rxp, txe, clash, ovf} = 5'h00;
  endtask
  task automatic push;
    logic [7:0] v;
    v = 8'($random(seed));
    wr(8'h9a, v);
    if (txn == 4)
      ovf = 1'b1;
    else
    begin
      txq.push_back(v);
      txn++;
    end
  endtask
  // Start a transaction, see busy, then poll until the bus is free
  task automatic go(input logic [7:0] t);
    int k;
    wr(8'he9, t);
    dir = t[0];
    repeat (4) @(posedge clock);
    rd(8'hea);
    `CHK("busy", 1'b1, d[7])
    for (k = 0; k < 4000 && d[7] === 1'b1; k++)
      rd(8'hea);
    `CHK("idle", 1'b0, d[7])
  endtask
  task automatic conclude;
    if (failures == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    seed = 32'h00c9;
    {clock_enable, rst_n, reg_write, reg_read, refuse} = 5'b10000;
    {reg_addr, reg_wdata} = 16'h0000;
    {txn, rxn, dir, noack, rxp, txe, clash, ovf} = '0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    txe = 1'b1;
    foreach (regs[k])
    begin
      rd(regs[k]);
      `CHK("reset", (regs[k] == 8'hea) ? exp_stat() : 8'h00, d)
    end
    wr(8'he8, 8'h80);
    wr(8'he9, {SLV, 1'b0});
    repeat (100) @(posedge clock);
    rd(8'he9);
    `CHK("target", {SLV, 1'b0}, d)
    `CHK("starts", 0, i2m_slave_model_inst.starts)
    wr(8'haf, 8'h01);
    rd(8'haf);
    `CHK("owner", 8'h01, d)
    @(posedge clock);
    {reg_addr, reg_wdata, reg_write, reg_read} <= {8'h9a, 8'h77, 2'b11};
    @(posedge clock);
    {reg_write, reg_read} <= 2'b00;
    clash = 1'b1;
    chk_stat();
    clr();
    chk_stat();
    for (r = 0; r < 5; r++)
    begin
      push();
      chk_stat();
    end
    clr();
    chk_stat();
    for (r = 0; r < 4; r++)
    begin
      wr(8'he8, {1'b1, 2'(r), 5'h00});
      if (r > 0)
        push();
      go({SLV, 1'b0});
      txn = 0;
      `CHK("sent", txq.size(), i2m_slave_model_inst.got.size())
      while (txq.size() > 0)
      begin
        e8 = txq.pop_front();
        g8 = i2m_slave_model_inst.got.pop_front();
        `CHK("sent", e8, g8)
      end
      chk_stat();
    end
    wr(8'he8, 8'h84);
    go({SLV, 1'b1});
    rxn = 4;
    chk_stat();
    for (r = 0; r < 4; r++)
    begin
      rd(8'h9b);
      `CHK("rx", 8'(P0 + r), d)
      rxn--;
    end
    chk_stat();
    wr(8'he8, 8'h80);
    go({SLV, 1'b1});
    rd(8'h9b);
    `CHK("rx", 8'(P0 + 5), d)
    s0 = i2m_slave_model_inst.starts;
    t0 = i2m_slave_model_inst.stops;
    wr(8'he9, {SLV, 1'b0});
    repeat (20) @(posedge clock);
    go({SLV, 1'b1});
    `CHK("starts", s0 + 2, i2m_slave_model_inst.starts)
    `CHK("stops", t0 + 1, i2m_slave_model_inst.stops)
    rd(8'h9b);
    `CHK("rx", 8'(P0 + 6), d)
    refuse <= 1'b1;
    push();
    push();
    go({SLV, 1'b0});
    {noack, txn} = {1'b1, 32'd0};
    txq.delete();
    chk_stat();
    clr();
    chk_stat();
    refuse <= 1'b0;
    push();
    wr(8'he9, {SLV, 1'b0});
    repeat (40) @(posedge clock);
    wr(8'he8, 8'h00);
    repeat (4) @(posedge clock);
    txn = 0;
    chk_stat();
    `CHK("lines", 2'b00, {scl_oe, sda_oe})
    conclude();
  end
endmodule // i2m_master_test
